// File: bench/ddr2_ctrl_model.sv
`timescale 1ns/1ps
module ddr2_ctrl_model
  import ddr2_pd_pkg::*;
(
  // clock
  input wire logic clk_in,
  // pins and decoded commands toward the device
  output logic cke_out,
  output logic odt_out,
  output logic nop_out,
  output logic [4:0] cmd_out,
  output logic [ADDR_W-1:0] addr_out
);
  // cmd_out bits: act, pre, ref, mr, emr; the clock is never stopped
  initial begin
    cke_out = 1'b1;
    odt_out = 1'b0;
    nop_out = 1'b1;
    cmd_out = 5'h00;
    addr_out = '0;
  end

  // one command pulse with new pin levels, then hold them
  task automatic step(input logic [4:0] c, input logic k, input logic o,
                      input logic [ADDR_W-1:0] a, input int n);
    @(negedge clk_in);
    cmd_out = c;
    nop_out = (c == 5'h00);
    cke_out = k;
    odt_out = o;
    addr_out = a;
    @(negedge clk_in);
    cmd_out = 5'h00;
    nop_out = 1'b1;
    addr_out = ~a;
    // never shorter than three registered levels
    repeat ((n < 3 ? 3 : n) - 1) @(negedge clk_in);
  endtask
endmodule

// File: bench/tb_ddr2_pd_odt_ctrl.sv
`timescale 1ns/1ps
module tb_ddr2_pd_odt_ctrl;
  import ddr2_pd_pkg::*;
  localparam logic [4:0] C_NOP = 5'h00;
  localparam logic [4:0] C_ACT = 5'h01;
  localparam logic [4:0] C_PRE = 5'h02;
  localparam logic [4:0] C_REF = 5'h04;
  localparam logic [4:0] C_MR = 5'h08;
  localparam logic [4:0] C_EMR = 5'h10;
  localparam logic [ADDR_W-1:0] A_RTT = 14'h0044;
  localparam logic [ADDR_W-1:0] A_SLOW = 14'h1000;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic busy = 1'b0;
  logic rd = 1'b0;
  logic rows = 1'b0;
  logic ce = 1'b1;
  logic cke;
  logic odt;
  logic nop;
  logic [4:0] cmd;
  logic [ADDR_W-1:0] addr;
  pwr_state_t pwr_state;
  logic term_on;
  logic term_async;
  logic [1:0] rtt;
  logic in_reset;
  logic resume;
  logic freq_ok;
  int n_fail = 0;
  int n_tests = 0;
  int n_resume = 0;

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  ddr2_ctrl_model i_ctrl (.clk_in(clk_in), .cke_out(cke), .odt_out(odt), .nop_out(nop),
    .cmd_out(cmd), .addr_out(addr));

  ddr2_pd_odt_ctrl i_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
    .cke_pin_in(cke), .odt_pin_in(odt), .cmd_nop_in(nop), .cmd_act_in(cmd[0]),
    .cmd_pre_in(cmd[1]), .cmd_ref_in(cmd[2]), .cmd_mr_in(cmd[3]), .cmd_emr_in(cmd[4]),
    .addr_in(addr), .burst_busy_in(busy), .burst_read_in(rd), .rows_open_in(rows),
    .pwr_state_out(pwr_state), .term_on_out(term_on), .term_async_out(term_async),
    .rtt_out(rtt), .in_reset_out(in_reset), .burst_resume_out(resume),
    .freq_change_ok_out(freq_ok));

  always @(posedge clk_in) begin
    if (resume === 1'b1) begin
      n_resume <= n_resume + 1;
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic s(input logic [4:0] c, input logic k, input logic o,
                   input logic [ADDR_W-1:0] a, input int n);
    i_ctrl.step(c, k, o, a, n);
  endtask

  task automatic st(input pwr_state_t e);
    chk("state", 8'(pwr_state), 8'(e));
  endtask

  task automatic tm(input logic on, input logic as);
    chk("term_on", 8'(term_on), 8'(on));
    chk("term_async", 8'(term_async), 8'(as));
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (12) @(negedge clk_in);
    srst_in = 1'b0;
    st(ST_INIT);
    s(C_NOP, 1, 0, 0, 6);
    s(C_MR, 1, 0, 0, 8);
    st(ST_ACTIVE);
    s(C_EMR, 1, 0, A_RTT, 8);
    chk("rtt", 8'(rtt), 8'h03);
    done("mode");
    // precharge power-down
    s(C_NOP, 1, 1, 0, 10);
    tm(1, 0);
    s(C_PRE, 1, 1, 0, 4);
    s(C_NOP, 0, 1, 0, 10);
    st(ST_PD_PRE);
    s(C_NOP, 0, 0, 0, 10);
    tm(0, 1);
    chk("freq_ok", 8'(freq_ok), 8'h01);
    s(C_NOP, 1, 0, 0, 16);
    st(ST_ACTIVE);
    chk("freq_ok", 8'(freq_ok), 8'h00);
    // dll reset after the frequency change, odt held off while relocking
    s(C_MR, 1, 0, 0, 200);
    chk("term_on", 8'(term_on), 8'h00);
    done("precharge_pd");
    // fast-exit active power-down
    rows = 1'b1;
    s(C_ACT, 1, 0, 0, 4);
    s(C_NOP, 0, 1, 0, 10);
    st(ST_PD_FAST);
    tm(1, 1);
    s(C_NOP, 1, 0, 0, 10);
    tm(0, 1);
    s(C_NOP, 1, 1, 0, 12);
    tm(1, 0);
    s(C_NOP, 1, 0, 0, 12);
    s(C_NOP, 0, 0, 0, 10);
    s(C_NOP, 0, 1, 0, 10);
    tm(1, 0);
    s(C_NOP, 1, 0, 0, 16);
    done("fast_pd");
    // slow-exit active power-down
    s(C_MR, 1, 0, A_SLOW, 8);
    s(C_NOP, 0, 0, 0, 10);
    st(ST_PD_SLOW);
    s(C_NOP, 0, 1, 0, 10);
    tm(1, 1);
    s(C_NOP, 0, 0, 0, 10);
    s(C_NOP, 1, 1, 0, 10);
    tm(1, 1);
    s(C_NOP, 1, 0, 0, 16);
    done("slow_pd");
    // self refresh ignores odt
    rows = 1'b0;
    s(C_PRE, 1, 0, 0, 4);
    s(C_REF, 0, 0, 0, 10);
    st(ST_SELF_REF);
    s(C_NOP, 0, 1, 0, 10);
    chk("term_on", 8'(term_on), 8'h00);
    s(C_NOP, 1, 0, 0, 16);
    st(ST_ACTIVE);
    done("self_refresh");
    // cke drops during a read burst
    busy = 1'b1;
    rd = 1'b1;
    s(C_NOP, 0, 0, 0, 10);
    busy = 1'b0;
    rd = 1'b0;
    st(ST_RESET);
    chk("in_reset", 8'(in_reset), 8'h01);
    chk("rtt", 8'(rtt), 8'h00);
    s(C_EMR, 0, 0, A_RTT, 8);
    chk("rtt", 8'(rtt), 8'h00);
    s(C_NOP, 1, 0, 0, 10);
    chk("resume", 8'(n_resume), 8'h01);
    chk("in_reset", 8'(in_reset), 8'h00);
    st(ST_INIT);
    s(C_MR, 1, 0, 0, 8);
    st(ST_ACTIVE);
    done("reset");
    // clock enable low: cke fall and mode write must both be ignored
    ce = 1'b0;
    s(C_EMR, 0, 0, A_RTT, 8);
    st(ST_ACTIVE);
    chk("rtt", 8'(rtt), 8'h00);
    ce = 1'b1;
    s(C_NOP, 1, 0, 0, 8);
    st(ST_ACTIVE);
    chk("rtt", 8'(rtt), 8'h00);
    done("clock_enable");
    finish_test();
  end
endmodule

// File: verilog/ddr2_pd_odt_ctrl.sv
`timescale 1ns/1ps
module ddr2_pd_odt_ctrl
  import ddr2_pd_pkg::*;
#(
  parameter int ANPD = ANPD_CYC,
  parameter int AXPD = AXPD_CYC,
  parameter int AOND = AOND_CYC,
  parameter int AOFD = AOFD_CYC,
  parameter int TMOD = TMOD_CYC
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // pins
  input wire logic cke_pin_in,
  input wire logic odt_pin_in,
  // decoded command, same clock
  input wire logic cmd_nop_in,
  input wire logic cmd_act_in,
  input wire logic cmd_pre_in,
  input wire logic cmd_ref_in,
  input wire logic cmd_mr_in,
  input wire logic cmd_emr_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic burst_busy_in,
  input wire logic burst_read_in,
  input wire logic rows_open_in,
  // status
  output pwr_state_t pwr_state_out,
  output logic term_on_out,
  output logic term_async_out,
  output logic [1:0] rtt_out,
  output logic in_reset_out,
  output logic burst_resume_out,
  output logic freq_change_ok_out
);
  logic [SYNC_STAGES-1:0] cke_s, odt_s, next_cke_s, next_odt_s;
  logic cke_lvl, odt_lvl, next_cke_lvl, next_odt_lvl;
  logic [CMD_W-1:0] cmd_d [CMD_DLY];
  logic [CMD_W-1:0] next_cmd_d [CMD_DLY];

  always_comb begin
    next_cke_s = {cke_s[SYNC_STAGES-2:0], cke_pin_in};
    next_odt_s = {odt_s[SYNC_STAGES-2:0], odt_pin_in};
    next_cke_lvl = cke_lvl;
    next_odt_lvl = odt_lvl;
    if (cke_s[1] == cke_s[2]) begin
      next_cke_lvl = cke_s[2];
    end
    if (odt_s[1] == odt_s[2]) begin
      next_odt_lvl = odt_s[2];
    end
    next_cmd_d[0] = {burst_read_in, burst_busy_in, cmd_ref_in, cmd_pre_in, cmd_act_in, cmd_nop_in};
    for (int i = 1; i < CMD_DLY; i++) begin
      next_cmd_d[i] = cmd_d[i-1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cke_s <= '0;
      odt_s <= '0;
      cke_lvl <= 1'b0;
      odt_lvl <= 1'b0;
      for (int i = 0; i < CMD_DLY; i++) begin
        cmd_d[i] <= '0;
      end
    end else if (ce_in) begin
      cke_s <= next_cke_s;
      odt_s <= next_odt_s;
      cke_lvl <= next_cke_lvl;
      odt_lvl <= next_odt_lvl;
      cmd_d <= next_cmd_d;
    end
  end

  logic [CMD_W-1:0] cmd;
  assign cmd = cmd_d[CMD_DLY-1];

  timer_if tmod_t ();
  timer_if axpd_t ();

  down_timer u_tmod (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .tmr(tmod_t.timer)
  );

  down_timer u_axpd (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .tmr(axpd_t.timer)
  );

  pwr_state_t state, next_state;
  last_cmd_t last_cmd, next_last_cmd;
  logic cke_prev, slow_exit, next_slow_exit, exit_slow, next_exit_slow;
  logic late_async, next_late_async, read_cut, next_read_cut;
  logic [1:0] rtt, next_rtt, rtt_pend_val, next_rtt_pend_val;
  logic rtt_pend, next_rtt_pend;
  logic [AOFD-1:0] odt_pipe, next_odt_pipe;
  logic [CNT_W-1:0] odt_age, next_odt_age, pd_cnt, next_pd_cnt;
  logic odt_prev;
  logic term, next_term, next_term_async, next_resume, next_freq_ok;
  logic cke_fall, cke_rise, odt_usable, async_on, async_off, odt_recent;

  assign cke_fall = cke_prev & ~cke_lvl;
  assign cke_rise = ~cke_prev & cke_lvl;
  // an odt move seen in this very cycle counts as inside the window
  assign odt_recent = odt_lvl != odt_prev || odt_age < CNT_W'(ANPD);
  assign tmod_t.load = CNT_W'(TMOD);
  assign axpd_t.load = CNT_W'(AXPD);
  assign tmod_t.start = ce_in && cmd_emr_in && state != ST_RESET;
  assign axpd_t.start = ce_in && cke_rise &&
    (state == ST_PD_FAST || state == ST_PD_SLOW || state == ST_PD_PRE);

  // termination allowed: enabled, settled, not in self refresh, reset or init
  assign odt_usable = rtt != RTT_OFF && !rtt_pend && !tmod_t.busy &&
    (state == ST_ACTIVE || state == ST_PD_FAST || state == ST_PD_SLOW || state == ST_PD_PRE);
  assign async_on = state == ST_PD_SLOW || state == ST_PD_PRE || late_async ||
    (axpd_t.busy && exit_slow);
  assign async_off = state == ST_PD_SLOW || state == ST_PD_PRE || late_async ||
    axpd_t.busy;

  always_comb begin
    next_state = state;
    next_last_cmd = last_cmd;
    next_slow_exit = slow_exit;
    next_exit_slow = exit_slow;
    next_late_async = late_async;
    next_read_cut = read_cut;
    next_rtt = rtt;
    next_rtt_pend = rtt_pend;
    next_rtt_pend_val = rtt_pend_val;
    next_resume = 1'b0;
    next_odt_pipe = {odt_pipe[AOFD-2:0], odt_lvl};
    next_odt_age = odt_age;
    next_pd_cnt = '0;
    if (odt_lvl != odt_prev) begin
      next_odt_age = 8'h01;
    end else if (odt_age < CNT_W'(ANPD)) begin
      next_odt_age = odt_age + 8'h01;
    end
    if (cmd[CMD_ACT]) begin
      next_last_cmd = LC_ACT;
    end else if (cmd[CMD_PRE]) begin
      next_last_cmd = LC_PRE;
    end else if (!cmd[CMD_NOP]) begin
      next_last_cmd = LC_NONE;
    end
    if (state != ST_RESET) begin
      if (cmd_mr_in) begin
        next_slow_exit = addr_in[MR_SLOW_EXIT_BIT];
      end
      if (cmd_emr_in) begin
        next_rtt_pend = 1'b1;
        next_rtt_pend_val = {addr_in[EMR_RTT_HI_BIT], addr_in[EMR_RTT_LO_BIT]};
      end else if (rtt_pend && !tmod_t.busy) begin
        next_rtt_pend = 1'b0;
        next_rtt = rtt_pend_val;
      end
    end
    case (state)
      ST_ACTIVE: begin
        if (cke_fall) begin
          if ((!cmd[CMD_NOP] && !cmd[CMD_REF]) || cmd[CMD_BUSY]) begin
            next_state = ST_RESET;
            next_read_cut = cmd[CMD_BUSY] && cmd[CMD_READ];
          end else if (cmd[CMD_REF]) begin
            next_state = ST_SELF_REF;
          end else begin
            next_late_async = odt_recent;
            if (last_cmd == LC_PRE || (last_cmd != LC_ACT && !rows_open_in)) begin
              next_state = ST_PD_PRE;
            end else if (slow_exit) begin
              next_state = ST_PD_SLOW;
            end else begin
              next_state = ST_PD_FAST;
            end
          end
        end
      end
      ST_PD_FAST, ST_PD_SLOW, ST_PD_PRE: begin
        if (state == ST_PD_PRE && pd_cnt < CNT_W'(FREQ_WAIT_CYC)) begin
          next_pd_cnt = pd_cnt + 8'h01;
        end else if (state == ST_PD_PRE) begin
          next_pd_cnt = pd_cnt;
        end
        if (cke_rise) begin
          next_state = ST_ACTIVE;
          next_exit_slow = state != ST_PD_FAST;
          next_late_async = 1'b0;
        end
      end
      ST_SELF_REF: begin
        if (cke_rise) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_RESET: begin
        if (cke_rise) begin
          next_state = ST_INIT;
          next_resume = read_cut;
          next_read_cut = 1'b0;
        end
      end
      ST_INIT: begin
        if (cmd_mr_in) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    if (next_state == ST_RESET) begin
      next_rtt = RTT_OFF;
      next_rtt_pend = 1'b0;
      next_late_async = 1'b0;
    end
    next_term = 1'b0;
    if (odt_usable && !term) begin
      next_term = async_on ? odt_lvl : odt_pipe[AOND-1];
    end else if (odt_usable) begin
      next_term = async_off ? odt_lvl : odt_pipe[AOFD-1];
    end
    next_term_async = next_term ? async_on : async_off;
    next_freq_ok = state == ST_PD_PRE && pd_cnt >= CNT_W'(FREQ_WAIT_CYC) && !odt_lvl;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_INIT;
      last_cmd <= LC_NONE;
      cke_prev <= 1'b0;
      odt_prev <= 1'b0;
      slow_exit <= 1'b0;
      exit_slow <= 1'b0;
      late_async <= 1'b0;
      read_cut <= 1'b0;
      rtt <= RTT_OFF;
      rtt_pend <= 1'b0;
      rtt_pend_val <= RTT_OFF;
      odt_pipe <= '0;
      odt_age <= '0;
      pd_cnt <= '0;
      term <= 1'b0;
      term_async_out <= 1'b0;
      burst_resume_out <= 1'b0;
      freq_change_ok_out <= 1'b0;
      in_reset_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      last_cmd <= next_last_cmd;
      cke_prev <= cke_lvl;
      odt_prev <= odt_lvl;
      slow_exit <= next_slow_exit;
      exit_slow <= next_exit_slow;
      late_async <= next_late_async;
      read_cut <= next_read_cut;
      rtt <= next_rtt;
      rtt_pend <= next_rtt_pend;
      rtt_pend_val <= next_rtt_pend_val;
      odt_pipe <= next_odt_pipe;
      odt_age <= next_odt_age;
      pd_cnt <= next_pd_cnt;
      term <= next_term;
      term_async_out <= next_term_async;
      burst_resume_out <= next_resume;
      freq_change_ok_out <= next_freq_ok;
      in_reset_out <= next_state == ST_RESET;
    end
  end

  assign pwr_state_out = state;
  assign term_on_out = term;
  assign rtt_out = rtt;

  AST_PD_PRE_ENTRY: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_ACTIVE && cke_fall && cmd[CMD_NOP] && !cmd[CMD_BUSY]
      && last_cmd == LC_PRE) |=> state == ST_PD_PRE)
    else $error("precharge power-down not entered after precharge");
  AST_ACT_PD_ENTRY: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_ACTIVE && cke_fall && cmd[CMD_NOP] && !cmd[CMD_BUSY]
      && last_cmd == LC_ACT) |=> (state == ST_PD_FAST || state == ST_PD_SLOW))
    else $error("active power-down not entered after activate");
  AST_RESET_ENTRY: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_ACTIVE && cke_fall && cmd[CMD_BUSY])
      |=> state == ST_RESET && in_reset_out && rtt_out == RTT_OFF)
    else $error("burst cut by cke did not enter reset");
  AST_RESET_DEAF: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == ST_RESET && $past(state) == ST_RESET && ce_in && cmd_emr_in)
      |=> !rtt_pend && rtt_out == RTT_OFF)
    else $error("mode write taken during reset");
  AST_RESUME: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_RESET && read_cut && cke_rise)
      |=> burst_resume_out && state == ST_INIT)
    else $error("interrupted read not resumed");
  AST_SELF_REF_OFF: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == ST_SELF_REF && $past(state) == ST_SELF_REF) |-> !term_on_out)
    else $error("termination on in self refresh");
  AST_SYNC_ON: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_ACTIVE && !axpd_t.busy && !late_async && odt_usable && !term
      && odt_pipe[AOND-1]) |=> term_on_out && !term_async_out)
    else $error("synchronous turn-on missed");
  AST_ASYNC_PD: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && (state == ST_PD_PRE || state == ST_PD_SLOW) && odt_usable && !term && odt_lvl)
      |=> term_on_out && term_async_out)
    else $error("asynchronous turn-on missed in power-down");
  AST_LATE_CHANGE: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_ACTIVE && cke_fall && cmd[CMD_NOP] && !cmd[CMD_BUSY]
      && odt_recent) |=> late_async)
    else $error("late odt change not made asynchronous");
  AST_AXPD_OFF: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && state == ST_ACTIVE && axpd_t.busy && term && odt_usable && !odt_lvl)
      |=> !term_on_out)
    else $error("early turn-off after exit not asynchronous");
  AST_RTT_UPDATE: assert property (@(posedge clk_in) disable iff (srst_in)
    (cmd_emr_in && ce_in && state == ST_ACTIVE)
      ##1 (ce_in && !cmd_emr_in && state != ST_RESET)[*4]
      |-> rtt_out == {$past(addr_in[EMR_RTT_HI_BIT], 4), $past(addr_in[EMR_RTT_LO_BIT], 4)})
    else $error("termination value not updated after tMOD");
endmodule

// File: verilog/ddr2_pd_pkg.sv
package ddr2_pd_pkg;
  localparam int ADDR_W = 14;
  localparam int CNT_W = 8;
  localparam int SYNC_STAGES = 3;
  // command flags are delayed to line up with the filtered cke level
  localparam int CMD_DLY = SYNC_STAGES + 1;
  localparam int CMD_W = 6;
  localparam int CMD_NOP = 0;
  localparam int CMD_ACT = 1;
  localparam int CMD_PRE = 2;
  localparam int CMD_REF = 3;
  localparam int CMD_BUSY = 4;
  localparam int CMD_READ = 5;
  localparam int MR_SLOW_EXIT_BIT = 12;
  localparam int EMR_RTT_HI_BIT = 6;
  localparam int EMR_RTT_LO_BIT = 2;
  localparam logic [1:0] RTT_OFF = 2'h0;
  localparam int TCK_PS = 8000;
  localparam int TMOD_NS = 12;
  localparam int TMOD_CYC = (TMOD_NS * 1000 + TCK_PS - 1) / TCK_PS;
  localparam int ANPD_CYC = 3;
  localparam int AXPD_CYC = 8;
  localparam int AOND_CYC = 2;
  localparam int AOFD_CYC = 3;
  localparam int FREQ_WAIT_CYC = 2;

  typedef enum logic [6:0] {
    ST_ACTIVE   = 7'h01,
    ST_PD_FAST  = 7'h02,
    ST_PD_SLOW  = 7'h04,
    ST_PD_PRE   = 7'h08,
    ST_SELF_REF = 7'h10,
    ST_RESET    = 7'h20,
    ST_INIT     = 7'h40
  } pwr_state_t;

  typedef enum logic [2:0] {
    LC_NONE = 3'h1,
    LC_ACT  = 3'h2,
    LC_PRE  = 3'h4
  } last_cmd_t;
endpackage

// File: verilog/down_timer.sv
`timescale 1ns/1ps
module down_timer
  import ddr2_pd_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // control
  timer_if.timer tmr
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (tmr.start) begin
      next_cnt = tmr.load;
    end else if (cnt != '0) begin
      next_cnt = cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt <= '0;
    end else if (ce_in) begin
      cnt <= next_cnt;
    end
  end

  assign tmr.busy = (cnt != '0);
endmodule

// File: verilog/timer_if.sv
`timescale 1ns/1ps
interface timer_if;
  import ddr2_pd_pkg::*;
  logic start;
  logic [CNT_W-1:0] load;
  logic busy;
  modport owner(output start, output load, input busy);
  modport timer(input start, input load, output busy);
endinterface
